// [inc/i2c_pkg.sv]
// Constants and types shared by both ends of the two-wire register link.
// Assumes a 20 MHz system clock on both ends.
package i2c_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Slave address after reset, eight-bit form with direction in bit 0
  localparam logic [7:0] DEFAULT_ADDR8 = 8'h88;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Longest clock hold imposed by the device, rounded down
  localparam int STRETCH_MAX_US = 100;
  localparam int STRETCH_MAX_CYC = STRETCH_MAX_US * (CLK_HZ / 1_000_000);
  localparam int STRETCH_CNT_W = $clog2(STRETCH_MAX_CYC + 1);

  // Host bit timing: one quarter of the serial clock period, rounded up
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QTR_CNT_W = $clog2(SCL_QTR_CYC + 1);

  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } cmd_t;

endpackage : i2c_pkg

// [inc/i2c_if.sv]
// Open-drain two-wire bus joining the host end and the device end.
// Each party drives a line low by raising its enable with output 0.
`timescale 1ns/10ps
`default_nettype none
interface i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: any enabled low driver wins
  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input scl, sda
  );
  modport dev (
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
    input scl, sda
  );
endinterface : i2c_if
`default_nettype wire

// [rtl/i2c_dev_end.sv]
// Device end: slave on the two-wire link giving register access with an
// auto-incrementing pointer, clock stretching and general-call reset.
// Assumes the register file answers reg_rdata_i in the cycle of reg_rd_o.
//
// How it works
// R1 - Hold clock low while busy
// R2 - Master waits while clock held low
// R3 - Any hold ends within 100 us
// R4 - Stretch right after acknowledge bit
// R5 - May stretch after start; master tolerates
// R6 - Master prefers repeated starts between commands
// R7 - First write byte loads register pointer
// R8 - Pointer advances by one per data byte
// R9 - Pointer survives repeated start until stop
// R10 - Auto-increment unless register is exempt
// R11 - Master writes zeros to reserved bits
// R12 - Recognise general call 0x06 to 0x00
// R13 - General call restores address 0x88
// R14 - Store byte at pointer, ack, advance
// R15 - Read: index write, repeated start, read
// R16 - Master ack continues read, nack ends
// R17 - Nack first cycle on wake from halt
// R18 - Ack only matching seven-bit address
`timescale 1ns/10ps
`default_nettype none
module i2c_dev_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial link
  i2c_if.dev bus,
  // Register file side
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_noinc_i,
  // Device status
  input wire logic busy_i,
  input wire logic halted_i,
  output logic wake_o,
  // Slave address
  input wire logic addr_we_i,
  input wire logic [6:0] addr_i,
  output logic [6:0] slave_addr_o,
  output logic gcall_rst_o
);
  import i2c_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} state_t;
  typedef enum logic [1:0] {B_ADDR, B_REG, B_DATA, B_GCALL} kind_t;

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  state_t state_q;
  kind_t kind_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [3:0] bits_q;
  logic [7:0] ptr_q;
  logic [6:0] saddr_q;
  logic rd_q;
  logic mack_ok_q;
  logic sda_low_q;
  logic stretch_q;
  logic [STRETCH_CNT_W-1:0] scnt_q;
  logic byte_end, ack_end, load_tx, stretch_req;
  logic addr_match, gcall_match;

  //////////////////////////////////////////////////////////////////////////
  // Line synchronisers and bus conditions

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= bus.scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // Byte framing and decode

  assign byte_end = (state_q == S_RX) && scl_fall && (bits_q == BYTE_BITS);
  assign ack_end = ((state_q == S_ACK) && scl_fall) ||
                   ((state_q == S_MACK) && scl_fall && mack_ok_q);
  // Fetch happens on the edge that ends an acknowledge before read data
  assign load_tx = ack_end && rd_q;
  assign reg_rd_o = load_tx;
  assign reg_addr_o = ptr_q;
  assign addr_match = (shift_q[7:1] == saddr_q); // see R18
  assign gcall_match = (shift_q[7:1] == GCALL_ADDR) && !shift_q[0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      kind_q <= B_ADDR;
      shift_q <= 8'h00;
      tx_q <= 8'hff;
      bits_q <= 4'h0;
      ptr_q <= PTR_RESET;
      rd_q <= 1'b0;
      mack_ok_q <= 1'b0;
      sda_low_q <= 1'b0;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      wake_o <= 1'b0;
      gcall_rst_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      wake_o <= 1'b0;
      gcall_rst_o <= 1'b0;
      if (start_det) begin
        // Pointer is kept here so a repeated start reads on from it
        state_q <= S_RX; // see R9
        kind_q <= B_ADDR;
        bits_q <= 4'h0;
        rd_q <= 1'b0;
        sda_low_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= S_IDLE;
        sda_low_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            sda_low_q <= 1'b0;
          end
          S_RX: begin
            if (scl_rise && bits_q != BYTE_BITS) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              bits_q <= bits_q + 4'h1;
            end else if (byte_end) begin
              state_q <= S_ACK;
              sda_low_q <= 1'b1;
              case (kind_q)
                B_ADDR: begin
                  if (addr_match && halted_i) begin
                    // Clock was stopped; this first cycle cannot be taken
                    wake_o <= 1'b1; // see R17
                    state_q <= S_IDLE;
                    sda_low_q <= 1'b0;
                  end else if (addr_match) begin
                    rd_q <= shift_q[0]; // see R15
                  end else if (gcall_match) begin
                    kind_q <= B_GCALL; // see R12
                  end else begin
                    state_q <= S_IDLE;
                    sda_low_q <= 1'b0;
                  end
                end
                B_REG: begin
                  ptr_q <= shift_q; // see R7
                end
                B_DATA: begin
                  reg_wdata_o <= shift_q; // see R14
                  reg_wr_o <= 1'b1; // see R14
                end
                B_GCALL: begin
                  if (shift_q == GCALL_RESET) begin
                    gcall_rst_o <= 1'b1; // see R12
                  end
                end
                default: begin
                  state_q <= S_IDLE;
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_low_q <= 1'b0;
              bits_q <= 4'h0;
              if (rd_q) begin
                tx_q <= reg_rdata_i; // see R16
                sda_low_q <= ~reg_rdata_i[7];
                state_q <= S_TX;
              end else begin
                state_q <= S_RX;
                case (kind_q)
                  B_ADDR: kind_q <= B_REG;
                  B_REG: kind_q <= B_DATA;
                  B_DATA: begin
                    if (!reg_noinc_i) begin
                      ptr_q <= ptr_q + 8'h01; // see R8, R10, R14
                    end
                  end
                  default: kind_q <= kind_q;
                endcase
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bits_q == BYTE_BITS - 4'h1) begin
                sda_low_q <= 1'b0;
                mack_ok_q <= 1'b0;
                state_q <= S_MACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b1};
                sda_low_q <= ~tx_q[6];
                bits_q <= bits_q + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              if (!sda_s2_q) begin
                mack_ok_q <= 1'b1;
                if (!reg_noinc_i) begin
                  ptr_q <= ptr_q + 8'h01; // see R8, R10, R16
                end
              end else begin
                // Not-acknowledge ends the read; wait for stop or restart
                state_q <= S_IDLE; // see R16
              end
            end else if (ack_end) begin
              tx_q <= reg_rdata_i;
              sda_low_q <= ~reg_rdata_i[7];
              bits_q <= 4'h0;
              state_q <= S_TX;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock stretching

  // A start stretch waits for the master's first low clock, so holding
  // the line never adds a clock edge that the byte framing would count
  assign stretch_req = busy_i && (ack_end || // see R4, R5
      (state_q == S_RX && kind_q == B_ADDR && bits_q == 4'h0 && scl_fall));

  // A hard limit keeps a stuck busy from hanging the bus forever
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stretch_q <= 1'b0;
      scnt_q <= '0;
    end else if (!stretch_q) begin
      stretch_q <= stretch_req; // see R1
      scnt_q <= '0;
    end else if (!busy_i ||
        scnt_q == STRETCH_CNT_W'(STRETCH_MAX_CYC - 1)) begin
      stretch_q <= 1'b0; // see R3
    end else begin
      scnt_q <= scnt_q + {{(STRETCH_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slave address register

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      saddr_q <= DEFAULT_ADDR8[7:1];
    end else if (gcall_rst_o) begin
      saddr_q <= DEFAULT_ADDR8[7:1]; // see R13
    end else if (addr_we_i) begin
      saddr_q <= addr_i;
    end
  end

  assign slave_addr_o = saddr_q;

  // Lines are only ever pulled low, never driven high
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_scl_oe = stretch_q;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_low_q;

endmodule : i2c_dev_end
`default_nettype wire

// [rtl/i2c_host_end.sv]
// Host end: bus master that runs start, stop, byte write and byte read
// commands on the two-wire link, generating the serial clock itself.
// Assumes it is the only master; no arbitration loss is detected.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial link
  i2c_if.host bus,
  // Command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire i2c_pkg::cmd_t cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_nack_i,
  // Results
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic acked_o
);
  import i2c_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} hstate_t;

  hstate_t state_q;
  logic [1:0] ph_q;
  logic [QTR_CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic [7:0] rx_q;
  logic scl_low_q, sda_low_q;
  logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic adv, tick;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers and phase timer

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= bus.scl;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Time stands still while the clock is released but held low by the
  // slave, so a stretch anywhere just lengthens the phase
  assign adv = scl_low_q || scl_s2_q; // see R2, R5
  assign tick = adv && (cnt_q == QTR_CNT_W'(SCL_QTR_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q == H_IDLE || tick) begin
      cnt_q <= '0;
    end else if (adv) begin
      cnt_q <= cnt_q + {{(QTR_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command sequencer

  assign cmd_ready_o = (state_q == H_IDLE);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= H_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      shift_q <= 9'h1ff;
      rx_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      acked_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmd_valid_i) begin
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            case (cmd_i)
              // Start while owning the bus is a repeated start
              CMD_START: state_q <= H_START; // see R6, R15
              CMD_STOP: state_q <= H_STOP;
              // Reserved bits are the caller's to zero
              CMD_WRITE: begin
                shift_q <= {cmd_data_i, 1'b1}; // see R11
                state_q <= H_BIT;
              end
              CMD_READ: begin
                shift_q <= {8'hff, cmd_nack_i}; // see R16
                state_q <= H_BIT;
              end
              default: state_q <= H_IDLE;
            endcase
          end
        end
        H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1;
                done_o <= 1'b1;
                state_q <= H_IDLE;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              default: begin
                done_o <= 1'b1;
                state_q <= H_IDLE;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_low_q <= ~shift_q[8];
              2'h1: scl_low_q <= 1'b0;
              2'h2: scl_low_q <= 1'b0;
              default: begin
                rx_q <= {rx_q[6:0], sda_s2_q};
                scl_low_q <= 1'b1;
                shift_q <= {shift_q[7:0], 1'b1};
                if (bit_q == BYTE_BITS) begin
                  rdata_o <= rx_q;
                  acked_o <= ~sda_s2_q;
                  done_o <= 1'b1;
                  state_q <= H_IDLE;
                end else begin
                  bit_q <= bit_q + 4'h1;
                end
              end
            endcase
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_low_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_low_q;

endmodule : i2c_host_end
`default_nettype wire

// [sim/i2c_link_checker.sv]
// Concurrent checks on the two-wire link between host end and device end.
// Assumes the plain signals of i2c_if plus the shared clock and reset.
`timescale 1ns/10ps
`default_nettype none
module i2c_link_checker
  import i2c_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Line levels
  input wire logic scl,
  input wire logic sda,
  // Driver controls
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic [STRETCH_CNT_W:0] hold_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current device clock hold
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !dev_scl_oe) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One cycle of slack covers the register that drops the hold
  a_stretch_bound: assert property (hold_q <= STRETCH_MAX_CYC + 1)
    else $error("device held the clock too long");
  a_stretch_origin: assert property ($rose(dev_scl_oe) |->
    ($past(scl) == 1'b0 || $past(sda) == 1'b0))
    else $error("clock hold began outside ack or start");
  a_dev_sda_steady: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_dev_pull_only: assert property ((dev_scl_oe | dev_sda_oe) |->
    !(dev_scl_o | dev_sda_o))
    else $error("device drove a line high");
  a_host_pull_only: assert property ((host_scl_oe | host_sda_oe) |->
    !(host_scl_o | host_sda_o))
    else $error("host drove a line high");
  a_host_waits: assert property ((!host_scl_oe && !scl) |=>
    (!host_scl_oe && $stable(host_sda_oe)))
    else $error("host moved on while clock held low");
  a_dev_reset_idle: assert property (disable iff (1'b0)
    sys_rst_i |=> (!dev_scl_oe && !dev_sda_oe))
    else $error("device drives the link in reset");
  a_host_reset_idle: assert property (disable iff (1'b0)
    sys_rst_i |=> (!host_scl_oe && !host_sda_oe))
    else $error("host drives the link in reset");
endmodule : i2c_link_checker
`default_nettype wire

// [sim/host_register_i2c_slave_test.sv]
// Self-checking bench: host end talks to device end over the link.
// Assumes one 20 MHz clock for both ends; the bench holds the registers.
`timescale 1ns/10ps
`default_nettype none
module host_register_i2c_slave_test;
  import i2c_pkg::*;
  // Arbitrary register exempt from pointer increment
  localparam logic [7:0] NOINC = 8'h3c;
  logic clk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, cmd_nack_i;
  logic done_o, acked_o, reg_wr_o, reg_rd_o, reg_noinc_i, busy_i;
  logic halted_i, wake_o, addr_we_i, gcall_rst_o;
  cmd_t cmd_i;
  logic [7:0] cmd_data_i, rdata_o, reg_addr_o, reg_wdata_o, reg_rdata_i, d;
  logic [6:0] addr_i, slave_addr_o, sa;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic [31:0] seed;
  int num_errors, n_checks, wakes, gcalls, ptr, rds;

  i2c_if bus();
  i2c_host_end u_i2c_host_end(.clk_i, .sys_rst_i, .bus(bus.host),
    .cmd_valid_i, .cmd_ready_o, .cmd_i, .cmd_data_i, .cmd_nack_i,
    .done_o, .rdata_o, .acked_o);
  i2c_dev_end u_i2c_dev_end(.clk_i, .sys_rst_i, .bus(bus.dev), .reg_addr_o,
    .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i, .reg_noinc_i,
    .busy_i, .halted_i, .wake_o, .addr_we_i, .addr_i, .slave_addr_o,
    .gcall_rst_o);
  i2c_link_checker u_i2c_link_checker(.clk_i, .sys_rst_i, .scl(bus.scl),
    .sda(bus.sda), .host_scl_o(bus.host_scl_o),
    .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .dev_scl_o(bus.dev_scl_o),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Register file behind the device; answers in the read pulse cycle
  assign reg_rdata_i = mem[reg_addr_o];
  assign reg_noinc_i = (reg_addr_o == NOINC);
  always @(posedge clk_i) begin
    if (reg_wr_o === 1'b1) mem[reg_addr_o] <= reg_wdata_o;
    if (wake_o === 1'b1) wakes++;
    if (gcall_rst_o === 1'b1) gcalls++;
    if (reg_rd_o === 1'b1) rds++;
  end

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Holds the request until the host takes it, then waits for completion
  task automatic cmd(input cmd_t k, input logic [7:0] v, input logic nk);
    int n;
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_i = k;
    cmd_data_i = v;
    cmd_nack_i = nk;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk1(done_o, 1'b1);
  endtask : cmd

  task automatic wbyte(input logic [7:0] v, input logic ack);
    cmd(CMD_WRITE, v, 1'b0);
    chk1(acked_o, ack);
  endtask : wbyte

  task automatic wr_seq(input logic [7:0] idx, input int n);
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa, 1'b0}, 1'b1);
    wbyte(idx, 1'b1);
    ptr = idx;
    repeat (n) begin
      d = rnd();
      wbyte(d, 1'b1);
      exp_mem[ptr] = d;
      chk8(mem[ptr], d);
      if (ptr != NOINC) ptr = (ptr + 1) % 256;
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk8(reg_addr_o, ptr[7:0]);
  endtask : wr_seq

  task automatic rd_seq(input logic [7:0] idx, input int n);
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa, 1'b0}, 1'b1);
    wbyte(idx, 1'b1);
    ptr = idx;
    rds = 0;
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      cmd(CMD_READ, 8'h00, i == n - 1);
      chk8(rdata_o, exp_mem[ptr]);
      if (i < n - 1 && ptr != NOINC) ptr = (ptr + 1) % 256;
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk8(rds[7:0], n[7:0]);
  endtask : rd_seq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b1;
    {cmd_valid_i, cmd_nack_i, busy_i, halted_i, addr_we_i} = 5'h00;
    cmd_i = CMD_START;
    cmd_data_i = 8'h00;
    addr_i = 7'h00;
    {num_errors, n_checks, wakes, gcalls, rds} = '0;
    seed = 32'hbfa3;
    sa = DEFAULT_ADDR8[7:1];
    for (int i = 0; i < 256; i++) begin
      mem[i] = rnd();
      exp_mem[i] = mem[i];
    end
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk8({1'b0, slave_addr_o}, {1'b0, sa});
    wr_seq(8'haa, 4);
    rd_seq(8'haa, 4);
    wr_seq(8'hff, 2);
    wr_seq(NOINC, 3);
    rd_seq(NOINC, 2);
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa ^ 7'h01, 1'b0}, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    // New address in 0x20..0x3f never meets the default or general call
    d = rnd();
    addr_i = {2'h1, d[4:0]};
    addr_we_i = 1'b1;
    @(negedge clk_i);
    addr_we_i = 1'b0;
    chk8({1'b0, slave_addr_o}, {1'b0, addr_i});
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa, 1'b0}, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    sa = addr_i;
    wr_seq(8'h20, 1);
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({GCALL_ADDR, 1'b0}, 1'b1);
    wbyte(GCALL_RESET, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk8(gcalls[7:0], 8'h01);
    chk8({1'b0, slave_addr_o}, DEFAULT_ADDR8 >> 1);
    sa = DEFAULT_ADDR8[7:1];
    // Second pass holds busy past the hold limit
    for (int k = 0; k < 2; k++) begin
      fork
        begin
          @(negedge clk_i);
          busy_i = 1'b1;
          repeat (k ? 2500 : 40 + rnd()) @(negedge clk_i);
          busy_i = 1'b0;
        end
        wr_seq(rnd(), 2);
      join
    end
    halted_i = 1'b1;
    cmd(CMD_START, 8'h00, 1'b0);
    wbyte({sa, 1'b0}, 1'b0);
    chk8(wakes[7:0], 8'h01);
    halted_i = 1'b0;
    cmd(CMD_STOP, 8'h00, 1'b0);
    wr_seq(8'h10, 1);
    summarize();
  end

  initial begin
    #3_000_000;
    num_errors++;
    summarize();
  end
endmodule : host_register_i2c_slave_test
`default_nettype wire
